/* File: include/fpue_pkg.sv */
// Purpose: Shared constants and types of the flash page update engine
// Assumes: 10 MHz core clock, 8-bit registers on a 32-bit AXI4-Lite slave
// Notes: Byte offsets are word aligned; each register sits in the low byte
package fpue_pkg;

    // Register byte offsets
    localparam logic [7:0] FPUE_OFS_CMD_STATUS = 8'he4;
    localparam logic [7:0] FPUE_OFS_ADDR_LOW = 8'he8;
    localparam logic [7:0] FPUE_OFS_ADDR_HIGH = 8'hec;
    localparam logic [7:0] FPUE_OFS_WRITE_DATA = 8'hf0;

    // Command codes
    localparam logic [7:0] FPUE_CMD_LOAD = 8'h00;
    localparam logic [7:0] FPUE_CMD_ERASE_PROGRAM = 8'h68;

    // Status bit positions
    localparam int FPUE_BIT_OP_INT = 0;
    localparam int FPUE_BIT_SEC_VIOL = 1;
    localparam int FPUE_BIT_HV_ERR = 2;
    localparam int FPUE_BIT_HV_ABORT = 3;

    // Reset values
    localparam logic [3:0] FPUE_STATUS_RESET = 4'h0;
    localparam logic [7:0] FPUE_ADDR_RESET = 8'h00;
    localparam logic [7:0] FPUE_DATA_RESET = 8'h00;

    // Page geometry
    localparam int FPUE_PAGE_BYTES = 64;
    localparam int FPUE_INDEX_W = 6;
    localparam int FPUE_SECTOR_BYTES = 1024;

    // Cycle timing
    localparam int FPUE_CLOCK_PERIOD_NS = 100;
    localparam int FPUE_PHASE_TIME_MS = 2;
    localparam int FPUE_CYCLE_TIME_MS = 4;
    localparam int FPUE_PHASE_CYCLES =
        (FPUE_PHASE_TIME_MS * 1000000 + FPUE_CLOCK_PERIOD_NS - 1) / FPUE_CLOCK_PERIOD_NS;

    // AXI responses
    localparam logic [1:0] FPUE_RESP_OKAY = 2'h0;
    localparam logic [1:0] FPUE_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        FPUE_IDLE,
        FPUE_ERASE,
        FPUE_PROGRAM
    } fpue_state_t;

    typedef struct packed {
        logic hvAbort;
        logic hvError;
        logic secViolation;
        logic opInterrupted;
    } fpue_status_t;

    typedef struct packed {
        logic eraseStart;
        logic eraseActive;
        logic programActive;
        logic byteWrite;
        logic [15:0] byteAddr;
        logic [7:0] byteData;
        logic [63:0] eraseMask;
    } fpue_flash_t;

endpackage : fpue_pkg

/* File: rtl/fpue_page_ram.sv */
// Purpose: Page buffer storage with one write port and a registered read port
// Assumes: Single clock; write and read may hit the same word in one cycle
// Notes: Read data show the old word when both ports hit the same word
`timescale 1ns/1ns
module fpue_page_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdData_q;

    initial begin
        if (WIDTH < 1 || DEPTH < 2) begin
            $error("fpue_page_ram: unsupported geometry");
        end
    end

    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= mem[rdAddr];
        end
    end

    assign rdData = rdData_q;

endmodule : fpue_page_ram

/* File: rtl/fpue_engine.sv */
// Purpose: Byte-selective erase and program sequencer for one code flash page
// Assumes: Core firmware on AXI4-Lite; flash array behind the flash port
// Notes: Stall output holds the core idle for the whole erase-program cycle
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Behaviour
// R01: Page buffer of 64 bytes with flags
// R02: Load command clears buffer and flags
// R03: Data write stores byte, sets flag
// R04: Index increments, wraps, keeps page bits
// R05: Firmware loads each location once only
// R06: Page from high and low bits 7:6
// R07: Only flagged bytes erased and programmed
// R08: Erase-program command starts cycle, stalls core
// R09: Status readable after the cycle ends
// R10: Interrupt aborts cycle, sets bit 0
// R11: Firmware checks abort flag and retries
// R12: Cycle lasts 2 ms erase, 2 ms program
// R13: Reads give status, writes clear status
// R14: Brownout blocks starting or continuing cycles
// R15: Firmware keeps loaded bytes in one page
// R16: Pages of 64 bytes in 1 kB sectors
// R17: Unsecured bytes stay readable as data
// R18: Secured page target sets bit 1
// R19: Abort sets bit 3, fault sets bit 2
// R20: Buffer and address writes ignored while busy
module fpue_engine
    import fpue_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PHASE_CYC = FPUE_PHASE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Core side
    input wire logic irqPending,
    output logic cpuStall,
    // Flash side
    input wire logic flashBrownoutDetect,
    input wire logic pageSecured,
    input wire logic hvGeneratorFault,
    output fpue_flash_t flashPort
);

    localparam int CNT_W = $clog2(PHASE_CYC + 1);
    localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE_CYC - 1);
    localparam logic [FPUE_INDEX_W:0] SWEEP_END = (FPUE_INDEX_W + 1)'(FPUE_PAGE_BYTES);

    initial begin
        if (ADDR_W < 8) begin
            $error("fpue_engine: ADDR_W must reach the register offsets");
        end
        if (PHASE_CYC < FPUE_PAGE_BYTES + 2) begin
            $error("fpue_engine: PHASE_CYC too short for a page sweep");
        end
        if (FPUE_SECTOR_BYTES % FPUE_PAGE_BYTES != 0) begin
            $error("fpue_engine: sectors must hold whole pages"); // R16
        end
    end

    fpue_state_t state_q;
    fpue_status_t status_q;
    logic [7:0] addrLow_q;
    logic [7:0] addrHigh_q;
    logic [FPUE_PAGE_BYTES-1:0] updateFlag_q;
    logic [CNT_W-1:0] phaseCnt_q;
    logic [FPUE_INDEX_W:0] sweepIdx_q;
    logic sweepValid_q;
    logic [FPUE_INDEX_W-1:0] sweepByte_q;
    logic bodSync1_q;
    logic bodSync2_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic awHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wHeld_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    fpue_flash_t flash_q;
    logic [7:0] ramRdData;

    logic wrFire;
    logic wrLow;
    logic busy;
    logic wrCmd;
    logic wrAddrLow;
    logic wrAddrHigh;
    logic wrData;
    logic wrMapped;
    logic [7:0] wrByte;
    logic startCycle;
    logic refuseBrownout;
    logic refuseSecure;
    logic abortIrq;
    logic abortBrownout;
    logic abortFault;
    logic abortAny;
    logic phaseDone;

    // Brownout arrives from the analog detector, so synchronise it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bodSync1_q <= 1'b0;
            bodSync2_q <= 1'b0;
        end else begin
            bodSync1_q <= flashBrownoutDetect;
            bodSync2_q <= bodSync1_q;
        end
    end

    // Write address and data are taken in either order and held
    assign awready = ~awHeld_q;
    assign wready = ~wHeld_q;
    assign wrFire = awHeld_q & wHeld_q & ~bvalid_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (awvalid && !awHeld_q) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
        end else if (wrFire) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (wvalid && !wHeld_q) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end else if (wrFire) begin
            wHeld_q <= 1'b0;
        end
    end

    function automatic logic hitReg(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
        hitReg = (addr == ADDR_W'(ofs));
    endfunction : hitReg

    assign busy = (state_q != FPUE_IDLE);
    assign wrLow = wrFire & wStrb_q[0];
    assign wrByte = wData_q[7:0];
    assign wrMapped = hitReg(awAddr_q, FPUE_OFS_CMD_STATUS) | hitReg(awAddr_q, FPUE_OFS_ADDR_LOW)
        | hitReg(awAddr_q, FPUE_OFS_ADDR_HIGH) | hitReg(awAddr_q, FPUE_OFS_WRITE_DATA);
    // Writes during a cycle are dropped so the flagged data stays put
    assign wrCmd = wrLow & ~busy & hitReg(awAddr_q, FPUE_OFS_CMD_STATUS); // R20
    assign wrAddrLow = wrLow & ~busy & hitReg(awAddr_q, FPUE_OFS_ADDR_LOW); // R20
    assign wrAddrHigh = wrLow & ~busy & hitReg(awAddr_q, FPUE_OFS_ADDR_HIGH); // R20
    assign wrData = wrLow & ~busy & hitReg(awAddr_q, FPUE_OFS_WRITE_DATA); // R20

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= FPUE_RESP_OKAY;
        end else if (wrFire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wrMapped ? FPUE_RESP_OKAY : FPUE_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // Read channel, answer one cycle after the address is taken
    assign arready = ~rvalid_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rresp_q <= FPUE_RESP_OKAY;
            rdata_q <= '0;
        end else if (arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= FPUE_RESP_OKAY;
            rdata_q <= '0;
            if (hitReg(araddr, FPUE_OFS_CMD_STATUS)) begin
                rdata_q <= {28'h0, status_q}; // R09 R13
            end else if (hitReg(araddr, FPUE_OFS_ADDR_LOW)) begin
                rdata_q <= {24'h0, addrLow_q};
            end else if (hitReg(araddr, FPUE_OFS_ADDR_HIGH)) begin
                rdata_q <= {24'h0, addrHigh_q};
            end else if (!hitReg(araddr, FPUE_OFS_WRITE_DATA)) begin
                rresp_q <= FPUE_RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

    // Address registers and auto-increment of the buffer index
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addrLow_q <= FPUE_ADDR_RESET;
            addrHigh_q <= FPUE_ADDR_RESET;
        end else begin
            if (wrAddrLow) begin
                addrLow_q <= wrByte;
            end else if (wrData) begin
                addrLow_q <= {addrLow_q[7:6], addrLow_q[5:0] + 6'h01}; // R04
            end
            if (wrAddrHigh) begin
                addrHigh_q <= wrByte;
            end
        end
    end

    // Update flags; the buffer reads as cleared through them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            updateFlag_q <= '0;
        end else if (wrCmd && wrByte == FPUE_CMD_LOAD) begin
            updateFlag_q <= '0; // R02
        end else if (wrData) begin
            updateFlag_q[addrLow_q[5:0]] <= 1'b1; // R03
        end
    end

    fpue_page_ram #(
        .WIDTH(8),
        .DEPTH(FPUE_PAGE_BYTES)
    ) i_fpue_page_ram ( // R01
        .clock(clock),
        .rst(rst),
        .wrEn(wrData), // R03
        .wrAddr(addrLow_q[5:0]),
        .wrData(wrByte),
        .rdAddr(sweepIdx_q[FPUE_INDEX_W-1:0]),
        .rdData(ramRdData)
    );

    // Start checks; a secured or starved page never begins a cycle
    assign startCycle = wrCmd & (wrByte == FPUE_CMD_ERASE_PROGRAM); // R08
    assign refuseSecure = startCycle & pageSecured; // R18
    assign refuseBrownout = startCycle & ~pageSecured & bodSync2_q; // R14
    assign abortIrq = busy & irqPending; // R10
    assign abortBrownout = busy & bodSync2_q; // R14
    assign abortFault = busy & hvGeneratorFault; // R19
    assign abortAny = abortIrq | abortBrownout | abortFault;
    assign phaseDone = (phaseCnt_q == PHASE_LAST);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= FPUE_IDLE;
        end else begin
            case (state_q)
                FPUE_IDLE: begin
                    if (startCycle && !pageSecured && !bodSync2_q) begin
                        state_q <= FPUE_ERASE; // R08
                    end
                end
                FPUE_ERASE: begin
                    if (abortAny) begin
                        state_q <= FPUE_IDLE; // R10
                    end else if (phaseDone) begin
                        state_q <= FPUE_PROGRAM; // R12
                    end
                end
                FPUE_PROGRAM: begin
                    if (abortAny || phaseDone) begin
                        state_q <= FPUE_IDLE; // R12
                    end
                end
                default: begin
                    state_q <= FPUE_IDLE;
                end
            endcase
        end
    end

    // One counter times both phases, so the cycle length ignores byte count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phaseCnt_q <= '0;
        end else if (!busy || abortAny || phaseDone) begin
            phaseCnt_q <= '0; // R12
        end else begin
            phaseCnt_q <= phaseCnt_q + CNT_W'(1);
        end
    end

    // Status: cleared by any command, set by events; a set wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_q <= FPUE_STATUS_RESET;
        end else begin
            if (wrCmd) begin
                status_q <= FPUE_STATUS_RESET; // R13
            end
            if (refuseSecure) begin
                status_q.secViolation <= 1'b1; // R18
            end
            if (refuseBrownout) begin
                status_q.hvAbort <= 1'b1; // R14
            end
            if (abortIrq) begin
                status_q.opInterrupted <= 1'b1; // R10
            end
            if (abortIrq || abortBrownout) begin
                status_q.hvAbort <= 1'b1; // R19
            end
            if (abortFault) begin
                status_q.hvError <= 1'b1; // R19
            end
        end
    end

    // Program sweep walks the buffer once, one cycle of read latency
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sweepIdx_q <= '0;
            sweepValid_q <= 1'b0;
            sweepByte_q <= '0;
        end else if (state_q != FPUE_PROGRAM || abortAny) begin
            sweepIdx_q <= '0;
            sweepValid_q <= 1'b0;
            sweepByte_q <= '0;
        end else begin
            sweepValid_q <= (sweepIdx_q != SWEEP_END);
            sweepByte_q <= sweepIdx_q[FPUE_INDEX_W-1:0];
            if (sweepIdx_q != SWEEP_END) begin
                sweepIdx_q <= sweepIdx_q + (FPUE_INDEX_W + 1)'(1);
            end
        end
    end

    // Flash port from flops; only flagged bytes see erase or write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flash_q <= '0;
        end else begin
            flash_q.eraseStart <= (state_q == FPUE_IDLE) && startCycle && !pageSecured
                && !bodSync2_q;
            flash_q.eraseActive <= (state_q == FPUE_ERASE) && !abortAny && !phaseDone;
            flash_q.programActive <= (state_q == FPUE_PROGRAM) && !abortAny && !phaseDone;
            flash_q.eraseMask <= updateFlag_q; // R07 R17
            flash_q.byteWrite <= (state_q == FPUE_PROGRAM) && !abortAny && sweepValid_q
                && updateFlag_q[sweepByte_q]; // R07
            flash_q.byteAddr <= {addrHigh_q, addrLow_q[7:6], sweepByte_q}; // R06 R16
            flash_q.byteData <= ramRdData;
        end
    end

    assign flashPort = flash_q;
    // Core stays in program-idle for as long as a cycle runs
    assign cpuStall = busy; // R08

endmodule : fpue_engine

/* File: tb/fpue_flash_model.sv */
// Purpose: Flash array model behind the engine flash port
// Assumes: Same clock as the engine
// Notes: Unwritten bytes read as erased, 8'hff
`timescale 1ns/1ns
module fpue_flash_model
    import fpue_pkg::*;
(
    input wire logic clock,
    input wire fpue_flash_t flashPort
);
    logic [7:0] mem [int];
    int nWrites;
    int nErases;
    initial begin
        nWrites = 0;
        nErases = 0;
    end
    always @(posedge clock) begin
        if (flashPort.eraseStart) begin
            nErases++;
        end
        if (flashPort.byteWrite) begin
            mem[int'(flashPort.byteAddr)] = flashPort.byteData;
            nWrites++;
        end
    end
    // Other bytes keep contents, readable as data
    function automatic logic [7:0] read_byte(input logic [15:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
    endfunction : read_byte
endmodule : fpue_flash_model

/* File: tb/fpue_engine_sva.sv */
// Purpose: Port checks of the flash page update engine
// Assumes: One clock, rst asynchronous active high
// Notes: Cycle length held by a counter, too long to unroll
`timescale 1ns/1ns
module fpue_engine_sva
    import fpue_pkg::*;
#(
    parameter int PHASE_CYC = 100
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic irqPending,
    input wire logic cpuStall,
    input wire fpue_flash_t flashPort
);
    int stallCnt_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stallCnt_q <= 0;
        end else begin
            stallCnt_q <= cpuStall ? stallCnt_q + 1 : 0;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_cycle_len;
        stallCnt_q <= 2 * PHASE_CYC;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle too long");
    property p_start_pulse;
        $rose(cpuStall) |-> ##[0:1] flashPort.eraseStart;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("no erase start");
    property p_phase_excl;
        !(flashPort.eraseActive && flashPort.programActive);
    endproperty
    a_phase_excl: assert property (p_phase_excl) else $error("phases overlap");
    property p_write_in_prog;
        flashPort.byteWrite |-> flashPort.programActive && cpuStall;
    endproperty
    a_write_in_prog: assert property (p_write_in_prog) else $error("write off phase");
    property p_write_flagged;
        flashPort.byteWrite |-> flashPort.eraseMask[flashPort.byteAddr[5:0]];
    endproperty
    a_write_flagged: assert property (p_write_flagged) else $error("unflagged write");
    property p_irq_abort;
        cpuStall && irqPending |=> !cpuStall;
    endproperty
    a_irq_abort: assert property (p_irq_abort) else $error("no abort on irq");
    property p_mask_frozen;
        cpuStall && $past(cpuStall) |-> $stable(flashPort.eraseMask);
    endproperty
    a_mask_frozen: assert property (p_mask_frozen) else $error("flags moved busy");
    property p_rdata_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_idle_quiet;
        !cpuStall |-> !flashPort.eraseActive && !flashPort.programActive;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("flash active idle");
endmodule : fpue_engine_sva
bind fpue_engine fpue_engine_sva #(.PHASE_CYC(PHASE_CYC)) i_fpue_engine_sva (
    .clock(clock), .rst(rst), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .irqPending(irqPending), .cpuStall(cpuStall), .flashPort(flashPort));

/* File: tb/fpue_engine_tb.sv */
// Purpose: Self-checking bench of the flash page update engine
// Assumes: AXI4-Lite master tasks, flash model on the far side
// Notes: Short phase count keeps the run brief
`timescale 1ns/1ns
module fpue_engine_tb
    import fpue_pkg::*;
;
    localparam int PC = 100;
    logic clock, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, irqPending, cpuStall, flashBrownoutDetect;
    logic pageSecured, hvGeneratorFault;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    fpue_flash_t flashPort;
    int n_errors, n_checks;
    fpue_engine #(.PHASE_CYC(PC)) i_fpue_engine (
        .clock(clock), .rst(rst), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irqPending(irqPending), .cpuStall(cpuStall),
        .flashBrownoutDetect(flashBrownoutDetect), .pageSecured(pageSecured),
        .hvGeneratorFault(hvGeneratorFault), .flashPort(flashPort));
    fpue_flash_model i_fpue_flash_model (.clock(clock), .flashPort(flashPort));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tick(inout int n);
        @(posedge clock);
        n++;
        if (n > 3 * PC) begin
            n_errors++;
            $display("[FAIL] wait expected done seen timeout");
            give_verdict();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            tick(n);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", FPUE_RESP_OKAY, bresp);
        // Idle edge so the next call never reassigns bready in this step
        tick(n);
    endtask : wr
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            tick(n);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        tick(n);
    endtask : axr
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(nm, {24'h0, e}, d);
        chk("rresp", FPUE_RESP_OKAY, r);
    endtask : rdchk
    task automatic wait_idle(output int n);
        n = 0;
        while (cpuStall) tick(n);
    endtask : wait_idle
    function automatic logic [7:0] next_low(input logic [7:0] a, input int k);
        return {a[7:6], a[5:0] + 6'(k)};
    endfunction : next_low
    function automatic logic [7:0] st(input bit opInt, input bit secViol,
        input bit hvErr, input bit hvAbort);
        return {4'h0, hvAbort, hvErr, secViol, opInt};
    endfunction : st
    initial begin
        logic [7:0] al, ah;
        logic [7:0] dat [8];
        logic [31:0] d;
        logic [1:0] r;
        int n, nw, ne;
        {awvalid, wvalid, bready, arvalid, rready, irqPending} = '0;
        {flashBrownoutDetect, pageSecured, hvGeneratorFault} = '0;
        {awaddr, araddr, wdata} = '0;
        n_errors = 0;
        n_checks = 0;
        rst = 1'b1;
        n = $urandom(32'h0c41);
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdchk("status", FPUE_OFS_CMD_STATUS, FPUE_STATUS_RESET);
        rdchk("addrLow", FPUE_OFS_ADDR_LOW, FPUE_ADDR_RESET);
        axr(8'h40, d, r);
        chk("unmapped", FPUE_RESP_SLVERR, r);
        $display("test reset done");
        // Contiguous load across the wrap, one page only
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_LOAD);
        ah = 8'($urandom);
        al = {2'($urandom), 6'd60};
        wr(FPUE_OFS_ADDR_HIGH, ah);
        wr(FPUE_OFS_ADDR_LOW, al);
        for (int k = 0; k < 8; k++) begin
            dat[k] = 8'($urandom);
            wr(FPUE_OFS_WRITE_DATA, dat[k]);
        end
        rdchk("addrLow", FPUE_OFS_ADDR_LOW, next_low(al, 8));
        nw = i_fpue_flash_model.nWrites;
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_ERASE_PROGRAM);
        wr(FPUE_OFS_ADDR_LOW, 8'h3f);
        wait_idle(n);
        chk("cycleLen", 1, n > 2 * PC - 20 && n <= 2 * PC);
        rdchk("status", FPUE_OFS_CMD_STATUS, st(0, 0, 0, 0));
        rdchk("addrLow", FPUE_OFS_ADDR_LOW, next_low(al, 8));
        chk("writes", 8, i_fpue_flash_model.nWrites - nw);
        for (int k = 0; k < 8; k++) begin
            d[7:0] = i_fpue_flash_model.read_byte({ah, next_low(al, k)});
            chk("flashByte", dat[k], d[7:0]);
        end
        $display("test program done");
        // Interrupt in mid-cycle, then any command clears status
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_ERASE_PROGRAM);
        repeat (20) @(posedge clock);
        irqPending <= 1'b1;
        @(posedge clock);
        irqPending <= 1'b0;
        wait_idle(n);
        chk("aborted", 1, n < PC);
        rdchk("status", FPUE_OFS_CMD_STATUS, st(1, 0, 0, 1));
        wr(FPUE_OFS_CMD_STATUS, 8'h01);
        rdchk("status", FPUE_OFS_CMD_STATUS, st(0, 0, 0, 0));
        $display("test abort done");
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_ERASE_PROGRAM);
        hvGeneratorFault <= 1'b1;
        @(posedge clock);
        hvGeneratorFault <= 1'b0;
        wait_idle(n);
        rdchk("status", FPUE_OFS_CMD_STATUS, st(0, 0, 1, 0));
        pageSecured <= 1'b1;
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_ERASE_PROGRAM);
        chk("stall", 0, cpuStall);
        rdchk("status", FPUE_OFS_CMD_STATUS, st(0, 1, 0, 0));
        pageSecured <= 1'b0;
        flashBrownoutDetect <= 1'b1;
        repeat (4) @(posedge clock);
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_ERASE_PROGRAM);
        chk("stall", 0, cpuStall);
        rdchk("status", FPUE_OFS_CMD_STATUS, st(0, 0, 0, 1));
        flashBrownoutDetect <= 1'b0;
        repeat (4) @(posedge clock);
        // Brownout in mid-cycle must stop the cycle early
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_ERASE_PROGRAM);
        flashBrownoutDetect <= 1'b1;
        wait_idle(n);
        flashBrownoutDetect <= 1'b0;
        chk("bodAbort", 1, n < PC);
        rdchk("status", FPUE_OFS_CMD_STATUS, st(0, 0, 0, 1));
        repeat (4) @(posedge clock);
        $display("test refusals done");
        // Load wipes flags: a bare cycle writes nothing
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_LOAD);
        nw = i_fpue_flash_model.nWrites;
        ne = i_fpue_flash_model.nErases;
        wr(FPUE_OFS_CMD_STATUS, FPUE_CMD_ERASE_PROGRAM);
        wait_idle(n);
        chk("writes", 0, i_fpue_flash_model.nWrites - nw);
        chk("erases", 1, i_fpue_flash_model.nErases - ne);
        $display("test load done");
        give_verdict();
    end
endmodule : fpue_engine_tb
